//--- bit_chain_checker_assertions.sv
// Checker for the bit chain shifter
module bit_chain_checker
#(
    parameter int WORDS = 8,
    parameter int IW    = 3
)
(
    input wire logic                clk,
    input wire logic                rst,
    input wire logic                shift_in,
    input wire logic                data_in,
    input wire logic                clear_in,
    input wire logic [IW-1:0]       first_word_index,
    input wire logic [IW-1:0]       end_word_index,
    input wire logic [WORDS*16-1:0] chain_out
);
    // Cycles since reset, saturating; pin history trusted from 5 on
    logic [2:0]          since_rst_q;
    logic [IW-1:0]       first_q;
    logic [IW-1:0]       end_q;
    logic [WORDS*16-1:0] chain_prev_q;
    always_ff @(posedge clk)
    begin
        if (rst)
            since_rst_q <= 3'h0;
        else if (since_rst_q != 3'h7)
            since_rst_q <= since_rst_q + 3'h1;
    end
    // Range and chain as they stood one edge back
    always_ff @(posedge clk)
    begin
        first_q      <= first_word_index;
        end_q        <= end_word_index;
        chain_prev_q <= chain_out;
    end
    property p_rst; @(posedge clk) disable iff (rst) $past(rst) |-> chain_out == '0; endproperty
    a_rst: assert property (p_rst) else $error("chain not zero after reset");
    // A pin change reaches the chain three edges later
    property p_held; @(posedge clk) disable iff (rst) since_rst_q >= 3'h5 && $past(shift_in, 3)
        && $past(shift_in, 4) && !$past(clear_in, 3) |-> $stable(chain_out);
    endproperty
    a_held: assert property (p_held) else $error("shift while held high");
    property p_idle; @(posedge clk) disable iff (rst) since_rst_q >= 3'h5
        && !$past(shift_in, 3) && !$past(clear_in, 3) |-> $stable(chain_out);
    endproperty
    a_idle: assert property (p_idle) else $error("chain moved while idle");
    property p_clear; @(posedge clk) disable iff (rst) since_rst_q >= 3'h5 && $past(clear_in, 3)
        && first_q == '0 && end_q == IW'(WORDS - 1) |-> chain_out == '0;
    endproperty
    a_clear: assert property (p_clear) else $error("clear left bits set");
    property p_data; @(posedge clk) disable iff (rst) since_rst_q >= 3'h5 && $past(shift_in, 3)
        && !$past(shift_in, 4) && !$past(clear_in, 3) |-> chain_out[first_q*16] == $past(data_in, 3);
    endproperty
    a_data: assert property (p_data) else $error("data bit not loaded");
    property p_move; @(posedge clk) disable iff (rst) since_rst_q >= 3'h5 && $past(shift_in, 3)
        && !$past(shift_in, 4) && !$past(clear_in, 3)
        |-> chain_out[first_q*16 + 1 +: 15] == chain_prev_q[first_q*16 +: 15];
    endproperty
    a_move: assert property (p_move) else $error("first word did not move up");
endmodule : bit_chain_checker
bind bit_chain_shifter bit_chain_checker #(.WORDS(WORDS), .IW(IW)) chk (.clk(clk), .rst(rst),
    .shift_in(shift_in), .data_in(data_in), .clear_in(clear_in),
    .first_word_index(first_word_index), .end_word_index(end_word_index),
    .chain_out(chain_out));

//--- bit_chain_consts.svh
// Constants for the multiword bit chain shifter
// Notes on behaviour
// - On a shift rising edge every bit in the selected word range moves one place toward the top.
// - Each shift loads the data input into bit 0 of the first word.
// - The bit leaving the top of the end word is dropped, kept nowhere.
// - While reset is high every word of the chain reads zero.
// - Reset beats a simultaneous shift edge; no shift then takes effect.
// - First index above end index: no error, first word shifts alone.
// - Words are 16 bits; bit 15 feeds bit 0 of the next word.
`ifndef BIT_CHAIN_CONSTS_SVH
`define BIT_CHAIN_CONSTS_SVH
`define WORD_BITS     16
`define WORD_COUNT    8
`define INDEX_BITS    3
`define CHAIN_RESET   16'h0000
`endif

//--- bit_chain_ctl.sv
// Controller model: one chain only, ranges never overlap
module bit_chain_ctl
(
    input wire logic clk,
    output logic     shift_in = 1'h0,
    output logic     data_in = 1'h0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Low gap after each rise so the synchroniser sees an edge
    task automatic pulse(input logic d, input int n);
        @(negedge clk);
        shift_in = 1'h1;
        data_in = d;
        repeat (n) @(negedge clk);
        shift_in = 1'h0;
        repeat (6) @(negedge clk);
    endtask : pulse
endmodule : bit_chain_ctl

//--- bit_chain_pkg.sv
// Types for the multiword bit chain shifter
`include "bit_chain_consts.svh"
package bit_chain_pkg;
    typedef logic [`WORD_BITS-1:0] word_t;
endpackage : bit_chain_pkg

//--- bit_chain_shifter.sv
// Multiword bit chain shift register over a selectable word range
`include "bit_chain_consts.svh"
module bit_chain_shifter
    import bit_chain_pkg::*;
#(
    parameter int WORDS = `WORD_COUNT,
    parameter int IW    = `INDEX_BITS
)
(
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   shift_in,
    input  wire logic                   data_in,
    input  wire logic                   clear_in,
    input  wire logic [IW-1:0]          first_word_index,
    input  wire logic [IW-1:0]          end_word_index,
    output logic [WORDS*`WORD_BITS-1:0] chain_out
);

    // Timing of one shift, counted in clock edges:
    //   edge 0  shift pin and data pin caught by the first flop
    //   edge 1  both levels reach the second flop, edge strobe rises
    //   edge 2  chain words take their new value
    // Clear follows the same two flop path, so a clear and a shift
    // that arrive together are seen together, and clear wins.
    // Data travels with shift through equal delay, so the bit that
    // enters the chain is the level the pin had with the shift rise.
    // Limitation: a shift pulse shorter than one clock may be missed;
    // the controller must hold each level for at least one clock.
    // Limitation: the range indices are taken as same clock signals;
    // changing them while a shift is in flight gives an undefined mix.
    // Trade-off: no carry output is kept, the top bit is simply lost,
    // which saves a flop and matches the required drop behaviour.

    // Word width kept local so slices below read plainly
    localparam int WB = `WORD_BITS;

    // Synchroniser stages; only stage 1 is read by logic
    logic [1:0]       shift_s_q;
    logic [1:0]       data_s_q;
    logic [1:0]       clear_s_q;

    // Edge detector state and its one cycle strobe
    logic             shift_prev_q;
    logic             shift_edge;

    // Cleaned pin levels after the second flop
    logic             shift_lvl;
    logic             data_lvl;
    logic             clear_lvl;

    // Per word decode of the active range
    logic [WORDS-1:0] range_mask;
    logic [WORDS-1:0] first_mask;
    logic [WORDS-1:0] carry_in;

    // Chain storage and next values, one word per entry
    word_t            words_q [WORDS];
    word_t            words_d [WORDS];

    // Word membership; first above end collapses range to the first word
    function automatic logic in_range
    (
        input int            w,
        input logic [IW-1:0] f,
        input logic [IW-1:0] e
    );
        logic [IW-1:0] top;
        logic [IW-1:0] idx;
        top = (f > e) ? f : e;
        idx = IW'(w);
        return (idx >= f) && (idx <= top);
    endfunction : in_range

    // Word w is the entry point of the chain
    function automatic logic is_first
    (
        input int            w,
        input logic [IW-1:0] f
    );
        logic [IW-1:0] idx;
        idx = IW'(w);
        return idx == f;
    endfunction : is_first

    // Shift pin synchroniser; the pin is asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shift_s_q <= 2'h0;
        end
        else
        begin
            shift_s_q <= {shift_s_q[0], shift_in};
        end
    end

    // Data pin synchroniser; same depth as shift keeps them aligned
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_s_q <= 2'h0;
        end
        else
        begin
            data_s_q <= {data_s_q[0], data_in};
        end
    end

    // Clear pin synchroniser; same depth so clear beats a shift
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clear_s_q <= 2'h0;
        end
        else
        begin
            clear_s_q <= {clear_s_q[0], clear_in};
        end
    end

    // Only the second stage leaves the synchronisers
    assign shift_lvl = shift_s_q[1];
    assign data_lvl  = data_s_q[1];
    assign clear_lvl = clear_s_q[1];

    // Previous shift level; resets to the idle low so no false edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            shift_prev_q <= 1'h0;
        end
        else
        begin
            shift_prev_q <= shift_lvl;
        end
    end

    // One strobe per rise; a held high level gives nothing more
    assign shift_edge = shift_lvl & ~shift_prev_q;

    // Range decode per word, shared by the update and carry paths
    generate
        for (genvar w = 0; w < WORDS; w++)
        begin : g_range
            assign range_mask[w] = in_range(w, first_word_index, end_word_index);
            assign first_mask[w] = is_first(w, first_word_index);
        end
    endgenerate

    // Carry into bit 0: data for the first word, word below otherwise
    generate
        for (genvar w = 0; w < WORDS; w++)
        begin : g_carry
            if (w == 0)
            begin : g_bottom
                assign carry_in[w] = data_lvl;
            end
            else
            begin : g_upper
                assign carry_in[w] = first_mask[w] ? data_lvl : words_q[w-1][WB-1];
            end
        end
    endgenerate

    // Next value of each word; words outside the range keep contents
    generate
        for (genvar w = 0; w < WORDS; w++)
        begin : g_next
            always_comb
            begin
                words_d[w] = words_q[w];
                if (clear_lvl && range_mask[w])
                begin
                    words_d[w] = `CHAIN_RESET;
                end
                else if (shift_edge && range_mask[w])
                begin
                    // Top bit feeds the next word's carry_in; at the top of the range it is kept nowhere
                    words_d[w] = {words_q[w][WB-2:0], carry_in[w]};
                end
            end
        end
    endgenerate

    // Chain registers; system reset clears every word whatever the range
    generate
        for (genvar w = 0; w < WORDS; w++)
        begin : g_word
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    words_q[w] <= `CHAIN_RESET;
                end
                else
                begin
                    words_q[w] <= words_d[w];
                end
            end
        end
    endgenerate

    // Flattened view, word w at bits w*WB upward, straight from flops
    generate
        for (genvar w = 0; w < WORDS; w++)
        begin : g_out
            assign chain_out[w*WB +: WB] = words_q[w];
        end
    endgenerate

    // Notes for integration:
    // a chain of several words is one long register, bit 15 of each
    // word feeding bit 0 of the next; three words give 48 bits.
    // Words outside the selected range are never touched by a shift
    // or a clear, so two chains over disjoint ranges can share the
    // storage; overlapping ranges give no dependable result.
    // The system reset clears all words; the clear pin only the range.
endmodule : bit_chain_shifter

//--- bit_chain_shifter_test.sv
// Self-checking bench for the bit chain shifter
`define CHK(a, b) n_tests++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t chain", $time); end
module bit_chain_shifter_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, clear_in = 0, shift_in, data_in;
    logic [2:0] fi = 3'h1, ei = 3'h2;
    logic [127:0] chain_out;
    logic [31:0] e = 32'h0;
    int n_mismatch = 0, n_tests = 0;
    bit_chain_ctl ctl (.clk(clk), .shift_in(shift_in), .data_in(data_in));
    bit_chain_shifter dut (.clk(clk), .rst(rst), .shift_in(shift_in), .data_in(data_in),
        .clear_in(clear_in), .first_word_index(fi), .end_word_index(ei), .chain_out(chain_out));
    initial forever #10 clk = ~clk;
    task automatic stop_test;
        $display("mismatches %0d tests %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : stop_test
    // Two words as one 32-bit chain, one long hold, top bit falls off
    task automatic t_chain;
        for (int i = 0; i < 34; i++)
        begin
            ctl.pulse(i % 3 == 0, i == 5 ? 9 : 2);
            e = {e[30:0], i % 3 == 0};
            `CHK(chain_out, {80'h0, e, 16'h0})
        end
    endtask : t_chain
    // First above end: word 3 alone, nothing spills over
    task automatic t_rev;
        fi = 3'h3;
        ei = 3'h1;
        repeat (17) ctl.pulse(1'h1, 2);
        `CHK(chain_out, {64'h0, 16'hFFFF, e, 16'h0})
    endtask : t_rev
    // Clear wins over a shift that arrives meanwhile
    task automatic t_clear;
        fi = 3'h0;
        ei = 3'h7;
        clear_in = 1'h1;
        repeat (3) @(negedge clk);
        ctl.pulse(1'h1, 2);
        clear_in = 1'h0;
        `CHK(chain_out, 128'h0)
    endtask : t_clear
    // Chain reads zero once reset lets go
    task automatic t_reset;
        repeat (3) @(negedge clk);
        rst = 1'h0;
        `CHK(chain_out, 128'h0)
    endtask : t_reset
    initial
    begin
        t_reset();
        t_chain();
        t_rev();
        t_clear();
        stop_test();
    end
    // Run takes some 10 us, so 100 us means a hang
    initial
    begin
        #100000;
        n_mismatch++;
        stop_test();
    end
endmodule : bit_chain_shifter_test
